// File: design/rtc_core.v
// real time clock: tick, time counter, alarm, wake and oscillator control
// Function
// R1: counting source is main or low-power oscillator; runs through idle and power down
// R2: registers reach software as plain ports standing for the peripheral bus side
// R3: cyclic request on each tick and after programmable tick count, to ext irq
// R4: provides a 58-bit timer for long interval measurement
// R5: with wake config set, leaves power down after programmed delay
// R6: tick divider input is clock pre-divided by fixed 64
// R7: 20-bit divider reloads from tick reload value every tick
// R8: tick request can fire once per tick period
// R9: 32-bit time counter, preloadable, increments each tick
// R10: time counter compared with 32-bit alarm; match raises alarm request
// R11: tick and alarm requests reach fast ext irq by source select, waking chip
// R12: oscillator-off bit switches off clock oscillator on power down entry
// R13: power down with block disabled stops both oscillators
// R14: low-power oscillation detected after reset selects it as counter reference
// R15: on low-power reference, main oscillator off in power down always
// R16: no low-power oscillation after reset selects main oscillator
// R17: on main reference and enabled, main oscillator kept running in power down
// R18: time counter wraps; alarm fires once per match event
`timescale 1ns/1ns
`default_nettype none
`include "rtc_map.vh"
module rtc_core (
  // clock and reset
  input wire clock_in,
  input wire reset_n_in,
  // oscillator pins (asynchronous)
  input wire low_power_osc_input_in,
  input wire lp_osc_ref_edge_in,
  // clock_block_control bits
  input wire rtc_enable_in,
  input wire osc_off_in_powerdown_in,
  input wire tick_irq_enable_in,
  input wire alarm_irq_enable_in,
  input wire periodic_irq_enable_in,
  // system_configuration bit
  input wire powerdown_wake_config_in,
  // ext_irq_source_select: 00 none, 01 tick or periodic, 10 alarm, 11 any
  input wire [1:0] ext_irq_source_select_in,
  // power management
  input wire powerdown_in,
  input wire idle_in,
  // values written by software
  input wire [19:0] tick_reload_value_in, // R2
  input wire time_load_in,
  input wire [31:0] time_load_value_in,
  input wire alarm_load_in,
  input wire [31:0] alarm_value_in,
  input wire [15:0] periodic_count_in,
  input wire [15:0] wake_delay_in,
  input wire long_timer_clear_in,
  // request flag clears
  input wire tick_clear_in,
  input wire alarm_clear_in,
  input wire periodic_clear_in,
  // requests
  output wire tick_irq_request_out,
  output wire alarm_irq_request_out,
  output wire periodic_irq_request_out,
  output wire ext_irq_out,
  output reg wake_out,
  // oscillator control
  output reg main_osc_enable_out,
  output reg lp_osc_enable_out,
  output reg clock_source_out,
  output reg source_valid_out,
  // state
  output reg [31:0] time_value_out,
  output reg [31:0] alarm_reg_out,
  output reg [57:0] long_timer_out,
  output reg tick_pulse_out
);
  reg lp_sync1_ff, lp_sync2_ff;
  reg ref_sync1_ff, ref_sync2_ff, ref_last_ff;
  reg tick_flag_ff, alarm_flag_ff, periodic_flag_ff;
  reg match_last_ff;
  reg [15:0] periodic_cnt_ff;
  reg [15:0] wake_cnt_ff;
  reg wake_armed_ff;
  wire lp_present;
  wire detect_done;
  wire tick;
  wire run;
  wire count_en;
  wire match;

  function [0:0] irq_select;
    input [1:0] sel;
    input t;
    input a;
    begin
      irq_select = (sel[0] & t) | (sel[1] & a);
    end
  endfunction

  // two-stage synchronisers on oscillator pins
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      lp_sync1_ff <= 1'b0;
      lp_sync2_ff <= 1'b0;
      ref_sync1_ff <= 1'b0;
      ref_sync2_ff <= 1'b0;
      ref_last_ff <= 1'b0;
    end else begin
      lp_sync1_ff <= low_power_osc_input_in;
      lp_sync2_ff <= lp_sync1_ff;
      ref_sync1_ff <= lp_osc_ref_edge_in;
      ref_sync2_ff <= ref_sync1_ff;
      ref_last_ff <= ref_sync2_ff;
    end
  end

  osc_detect u_detect (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .lp_level_in(lp_sync2_ff),
    .lp_present_out(lp_present),
    .done_out(detect_done)
  );

  // source latched once detection completes after reset
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      clock_source_out <= `RTC_SRC_MAIN;
      source_valid_out <= 1'b0;
    end else if (detect_done && !source_valid_out) begin
      clock_source_out <= lp_present ? `RTC_SRC_LOWPWR : `RTC_SRC_MAIN; // R14 R16
      source_valid_out <= 1'b1;
    end
  end

  // low-power reference counts on its own rising edge; main counts every clock
  assign run = rtc_enable_in & source_valid_out; // R1
  assign count_en = (clock_source_out == `RTC_SRC_LOWPWR) ?
                    (ref_sync2_ff & ~ref_last_ff) : 1'b1; // R1

  tick_divider u_div (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .run_in(run),
    .count_en_in(count_en),
    .reload_in(tick_reload_value_in), // R6 R7
    .tick_out(tick)
  );

  // time counter, alarm, long timer
  assign match = (time_value_out == alarm_reg_out); // R10

  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      time_value_out <= 32'h0000_0000;
      alarm_reg_out <= 32'hFFFF_FFFF;
      long_timer_out <= 58'h000_0000_0000_0000;
      match_last_ff <= 1'b1;
      tick_pulse_out <= 1'b0;
    end else begin
      tick_pulse_out <= tick;
      if (time_load_in)
        time_value_out <= time_load_value_in; // R9
      else if (tick)
        time_value_out <= time_value_out + 32'h0000_0001; // R9 R18
      if (alarm_load_in)
        alarm_reg_out <= alarm_value_in; // R10
      if (long_timer_clear_in)
        long_timer_out <= 58'h000_0000_0000_0000;
      else if (tick)
        long_timer_out <= long_timer_out + 58'h000_0000_0000_0001; // R4
      match_last_ff <= match;
    end
  end

  // sticky request flags; a set in the clearing cycle wins
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      tick_flag_ff <= 1'b0;
      alarm_flag_ff <= 1'b0;
      periodic_flag_ff <= 1'b0;
      periodic_cnt_ff <= 16'h0000;
    end else begin
      if (tick && tick_irq_enable_in)
        tick_flag_ff <= 1'b1; // R8
      else if (tick_clear_in)
        tick_flag_ff <= 1'b0;
      // edge of match only, so a held equality fires once
      if (match && !match_last_ff && run && alarm_irq_enable_in)
        alarm_flag_ff <= 1'b1; // R10 R18
      else if (alarm_clear_in)
        alarm_flag_ff <= 1'b0;
      if (!periodic_irq_enable_in) begin
        periodic_cnt_ff <= 16'h0000;
        if (periodic_clear_in)
          periodic_flag_ff <= 1'b0;
      end else if (tick && periodic_cnt_ff >= periodic_count_in) begin
        periodic_cnt_ff <= 16'h0000;
        periodic_flag_ff <= 1'b1; // R3
      end else begin
        if (tick)
          periodic_cnt_ff <= periodic_cnt_ff + 16'h0001;
        if (periodic_clear_in)
          periodic_flag_ff <= 1'b0;
      end
    end
  end

  assign tick_irq_request_out = tick_flag_ff; // R8
  assign alarm_irq_request_out = alarm_flag_ff; // R10
  assign periodic_irq_request_out = periodic_flag_ff; // R3
  assign ext_irq_out = irq_select(ext_irq_source_select_in,
                                  tick_flag_ff | periodic_flag_ff,
                                  alarm_flag_ff); // R3 R11

  // wake from power down after a delay counted in ticks
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      wake_cnt_ff <= 16'h0000;
      wake_armed_ff <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      wake_out <= 1'b0;
      if (!powerdown_in || !powerdown_wake_config_in) begin
        wake_cnt_ff <= 16'h0000;
        // re-armed outside power down, so config may rise together with entry
        wake_armed_ff <= 1'b1; // R5
      end else if (wake_armed_ff && tick) begin
        if (wake_cnt_ff >= wake_delay_in) begin
          wake_out <= 1'b1; // R5
          wake_armed_ff <= 1'b0;
        end else begin
          wake_cnt_ff <= wake_cnt_ff + 16'h0001;
        end
      end
      if (powerdown_in && irq_select(ext_irq_source_select_in,
                                     tick_flag_ff | periodic_flag_ff, alarm_flag_ff))
        wake_out <= 1'b1; // R11
    end
  end

  // oscillator enables for power down
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      main_osc_enable_out <= 1'b1;
      lp_osc_enable_out <= 1'b1;
    end else if (!powerdown_in) begin
      main_osc_enable_out <= 1'b1;
      lp_osc_enable_out <= 1'b1;
    end else if (!rtc_enable_in) begin
      main_osc_enable_out <= 1'b0; // R13
      lp_osc_enable_out <= 1'b0; // R13
    end else if (clock_source_out == `RTC_SRC_LOWPWR) begin
      main_osc_enable_out <= 1'b0; // R15
      lp_osc_enable_out <= ~osc_off_in_powerdown_in; // R12
    end else begin
      main_osc_enable_out <= ~osc_off_in_powerdown_in; // R12 R17
      lp_osc_enable_out <= 1'b0;
    end
  end

  // idle leaves counting untouched: nothing gates on it
  wire unused_idle = idle_in;
endmodule // rtc_core
`default_nettype wire

// File: design/rtc_map.vh
// constants for the real time clock block
`ifndef RTC_MAP_VH
`define RTC_MAP_VH
`define RTC_PREDIV_COUNT 6'h3F
`define RTC_PREDIV_W 6
`define RTC_DIV_W 20
`define RTC_TIME_W 32
`define RTC_LONG_W 58
`define RTC_CNT_W 16
`define RTC_RELOAD_RST 20'h0_0000
`define RTC_DETECT_WINDOW 16'h0400
`define RTC_DETECT_EDGES 8'h08
`define RTC_SRC_MAIN 1'b0
`define RTC_SRC_LOWPWR 1'b1
`endif

// File: design/osc_detect.v
// detects low-power oscillator activity after reset
`timescale 1ns/1ns
`default_nettype none
`include "rtc_map.vh"
module osc_detect (
  // clock and reset
  input wire clock_in,
  input wire reset_n_in,
  // sampled low-power oscillator level (already synchronised)
  input wire lp_level_in,
  // result
  output reg lp_present_out,
  output reg done_out
);
  reg [15:0] window_ff;
  reg [7:0] edges_ff;
  reg last_ff;

  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      window_ff <= 16'h0000;
      edges_ff <= 8'h00;
      last_ff <= 1'b0;
      lp_present_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      last_ff <= lp_level_in;
      if (!done_out) begin
        window_ff <= window_ff + 16'h0001;
        if (lp_level_in != last_ff && edges_ff != 8'hFF)
          edges_ff <= edges_ff + 8'h01;
        if (window_ff == `RTC_DETECT_WINDOW) begin
          done_out <= 1'b1;
          lp_present_out <= (edges_ff >= `RTC_DETECT_EDGES);
        end
      end
    end
  end
endmodule // osc_detect
`default_nettype wire

// File: design/tick_divider.v
// fixed 1/64 pre-divider and reloading 20-bit tick divider
`timescale 1ns/1ns
`default_nettype none
`include "rtc_map.vh"
module tick_divider (
  // clock and reset
  input wire clock_in,
  input wire reset_n_in,
  // control
  input wire run_in,
  input wire count_en_in,
  input wire [19:0] reload_in,
  // tick
  output reg tick_out
);
  reg [5:0] pre_ff;
  reg [19:0] div_ff;

  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      pre_ff <= 6'h00;
      div_ff <= `RTC_RELOAD_RST;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (!run_in) begin
        pre_ff <= 6'h00;
        div_ff <= reload_in;
      end else if (count_en_in) begin
        if (pre_ff == `RTC_PREDIV_COUNT) begin
          pre_ff <= 6'h00;
          if (div_ff == 20'h0_0000) begin
            div_ff <= reload_in;
            tick_out <= 1'b1;
          end else begin
            div_ff <= div_ff - 20'h0_0001;
          end
        end else begin
          pre_ff <= pre_ff + 6'h01;
        end
      end
    end
  end
endmodule // tick_divider
`default_nettype wire

// File: dv/lp_osc_model.sv
// stand-in for the low-power crystal, silent when absent or switched off
`timescale 1ns/1ns
`default_nettype none
module lp_osc_model #(
  parameter int HALF = 3
) (
  // clock
  input wire logic clock_in,
  // crystal fitted, oscillator enabled by the core
  input wire logic present_in,
  input wire logic enable_in,
  // pin level and counting reference
  output logic level_out,
  output logic edge_out
);
  int cnt = 0;
  initial level_out = 1'b0;
  // sped up: the presence window spans under two periods of a true 32 kHz crystal
  always @(negedge clock_in) begin
    if (present_in && enable_in) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) level_out <= ~level_out;
    end
  end
  assign edge_out = level_out;
endmodule // lp_osc_model
`default_nettype wire

// File: dv/rtc_core_checker.sv
// port assertions for the real time clock core
`timescale 1ns/1ns
`default_nettype none
module rtc_core_checker (
  // clock, reset, controls
  input wire logic clock_in, reset_n_in, rtc_enable_in, osc_off_in_powerdown_in, powerdown_in,
  input wire logic alarm_load_in, time_load_in,
  input wire logic [1:0] ext_irq_source_select_in,
  input wire logic [31:0] alarm_value_in, time_load_value_in,
  // requests and state
  input wire logic tick_irq_request_out, alarm_irq_request_out, periodic_irq_request_out,
  input wire logic ext_irq_out, main_osc_enable_out, lp_osc_enable_out, clock_source_out,
  input wire logic tick_pulse_out,
  input wire logic [31:0] time_value_out, alarm_reg_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  reset_vals_a: assert property (disable iff (1'b0) !reset_n_in |=>
    alarm_reg_out == 32'hFFFF_FFFF && time_value_out == 32'h0000_0000 && !clock_source_out)
    else $error("reset values wrong");
  alarm_load_a: assert property (alarm_load_in |=> alarm_reg_out == $past(alarm_value_in))
    else $error("alarm load lost");
  time_load_a: assert property (time_load_in |=> time_value_out == $past(time_load_value_in))
    else $error("time load lost");
  tick_flag_a: assert property ($rose(tick_irq_request_out) |-> tick_pulse_out)
    else $error("tick flag without tick");
  tick_gap_a: assert property (tick_pulse_out |=> !tick_pulse_out [*8])
    else $error("ticks too close");
  stop_count_a: assert property ((!rtc_enable_in) [*3] |-> !tick_pulse_out)
    else $error("tick while disabled");
  ext_route_a: assert property (ext_irq_out ==
    (ext_irq_source_select_in[0] && (tick_irq_request_out || periodic_irq_request_out)
    || ext_irq_source_select_in[1] && alarm_irq_request_out)) else $error("ext irq wrong");
  both_off_a: assert property ((powerdown_in && !rtc_enable_in) [*2] |->
    !main_osc_enable_out && !lp_osc_enable_out) else $error("oscillators left on");
  lp_src_a: assert property ((powerdown_in && clock_source_out) [*2] |->
    !main_osc_enable_out) else $error("main osc on");
  main_src_a: assert property ((powerdown_in && rtc_enable_in && !clock_source_out
    && !osc_off_in_powerdown_in) [*2] |-> main_osc_enable_out) else $error("main osc off");
  osc_off_a: assert property ((powerdown_in && osc_off_in_powerdown_in) [*2] |->
    (clock_source_out ? !lp_osc_enable_out : !main_osc_enable_out)) else $error("osc not off");
endmodule // rtc_core_checker
bind rtc_core rtc_core_checker u_rtc_core_checker (.*);
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the real time clock core
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock_in = 0, reset_n_in = 0, rtc_enable_in = 0, osc_off_in_powerdown_in = 0;
  logic tick_irq_enable_in = 0, alarm_irq_enable_in = 0, periodic_irq_enable_in = 0;
  logic powerdown_wake_config_in = 0, powerdown_in = 0, idle_in = 0, time_load_in = 0;
  logic alarm_load_in = 0, long_timer_clear_in = 0, tick_clear_in = 0, alarm_clear_in = 0;
  logic periodic_clear_in = 0, lp_present = 0;
  logic [1:0] ext_irq_source_select_in = 2'h0;
  logic [19:0] tick_reload_value_in = 20'h0_0000;
  logic [31:0] time_load_value_in = 32'h0000_0000, alarm_value_in = 32'h0000_0000;
  logic [15:0] periodic_count_in = 16'h0002, wake_delay_in = 16'h0000;
  wire low_power_osc_input_in, lp_osc_ref_edge_in, tick_irq_request_out, alarm_irq_request_out;
  wire periodic_irq_request_out, ext_irq_out, wake_out, main_osc_enable_out, lp_osc_enable_out;
  wire clock_source_out, source_valid_out, tick_pulse_out;
  wire [31:0] time_value_out, alarm_reg_out;
  wire [57:0] long_timer_out;
  int fails = 0, num_checks = 0, n;
  rtc_core u_rtc_core (.*);
  lp_osc_model u_lp_osc_model (.clock_in(clock_in), .present_in(lp_present),
    .enable_in(lp_osc_enable_out), .level_out(low_power_osc_input_in),
    .edge_out(lp_osc_ref_edge_in));
  always #25 clock_in = ~clock_in;
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input string what, input logic [57:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic next_tick(output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (tick_pulse_out !== 1'b1 && k < 5000);
  endtask
  task automatic do_reset(input logic present);
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    lp_present <= present;
    cyc(7);
    chk("alarm after reset", 32'hFFFF_FFFF, alarm_reg_out);
    @(posedge clock_in) reset_n_in <= 1'b1;
    n = 0;
    while (source_valid_out !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    chk("source valid", 1, source_valid_out);
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    chk("source", 0, clock_source_out);
    // reload 1 gives one tick per 128 clocks
    @(posedge clock_in);
    tick_reload_value_in <= 20'h0_0001;
    time_load_in <= 1'b1;
    time_load_value_in <= 32'hFFFF_FFFE;
    rtc_enable_in <= 1'b1;
    tick_irq_enable_in <= 1'b1;
    @(posedge clock_in) time_load_in <= 1'b0;
    next_tick(n);
    next_tick(n);
    chk("tick period", 128, n);
    chk("time wrap", 0, time_value_out);
    chk("tick flag", 1, tick_irq_request_out);
    chk("long timer", 2, long_timer_out);
    @(posedge clock_in);
    tick_clear_in <= 1'b1;
    alarm_load_in <= 1'b1;
    alarm_value_in <= 32'h0000_0002;
    alarm_irq_enable_in <= 1'b1;
    ext_irq_source_select_in <= 2'h2;
    long_timer_clear_in <= 1'b1;
    periodic_irq_enable_in <= 1'b1;
    @(posedge clock_in);
    tick_clear_in <= 1'b0;
    alarm_load_in <= 1'b0;
    long_timer_clear_in <= 1'b0;
    next_tick(n);
    chk("alarm early", 0, alarm_irq_request_out);
    next_tick(n);
    cyc(1);
    chk("alarm flag", 1, alarm_irq_request_out);
    chk("ext irq", 1, ext_irq_out);
    chk("long after clear", 2, long_timer_out);
    chk("periodic early", 0, periodic_irq_request_out);
    @(posedge clock_in) alarm_clear_in <= 1'b1;
    @(posedge clock_in) alarm_clear_in <= 1'b0;
    next_tick(n);
    cyc(1);
    chk("alarm once", 0, alarm_irq_request_out);
    chk("periodic flag", 1, periodic_irq_request_out);
    chk("ext irq masked", 0, ext_irq_out);
    @(posedge clock_in);
    ext_irq_source_select_in <= 2'h0;
    wake_delay_in <= 16'h0001;
    powerdown_in <= 1'b1;
    powerdown_wake_config_in <= 1'b1;
    n = 0;
    while (wake_out !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("wake", 1, wake_out);
    chk("main kept", 1, main_osc_enable_out);
    @(posedge clock_in) osc_off_in_powerdown_in <= 1'b1;
    cyc(2);
    chk("main off", 0, main_osc_enable_out);
    @(posedge clock_in);
    osc_off_in_powerdown_in <= 1'b0;
    rtc_enable_in <= 1'b0;
    cyc(2);
    chk("both off", 0, {main_osc_enable_out, lp_osc_enable_out});
    @(posedge clock_in) powerdown_in <= 1'b0;
    do_reset(1'b1);
    chk("lp source", 1, clock_source_out);
    @(posedge clock_in);
    powerdown_in <= 1'b1;
    rtc_enable_in <= 1'b1;
    cyc(2);
    chk("main off lp", 0, main_osc_enable_out);
    next_tick(n);
    chk("lp tick", 1, tick_pulse_out);
    stop_test();
  end
  initial begin
    #(50 * 20000);
    fails++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
